/* File: shared/bsc_regs.svh */
// register offsets, field positions, reset values and crc constants
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH
`define BSC_OFS_CONTROL 4'h0
`define BSC_OFS_DATA_LOW 4'h4
`define BSC_OFS_DATA_HIGH 4'h8
`define BSC_BIT_RESET_TRIGGER 0
`define BSC_BIT_SEED_SELECT 1
`define BSC_BIT_ORDER_SELECT 2
`define BSC_CONTROL_RESET 8'h00
`define BSC_CONTROL_WMASK 8'h06
`define BSC_POLY 16'h1021
`define BSC_SEED_ZERO 16'h0000
`define BSC_SEED_ONES 16'hffff
`endif

/* File: shared/bsc_pkg.sv */
// types shared by the checksum calculator
`default_nettype none
package bsc_pkg;
  typedef enum logic [1:0] {
    BSC_IDLE = 2'b00,
    BSC_ACK = 2'b01
  } bsc_bus_t;
endpackage : bsc_pkg
`default_nettype wire

/* File: logic/bsc_crc_step.sv */
// one byte of ccitt crc update, either bit order
`default_nettype none
`include "bsc_regs.svh"
module bsc_crc_step (
  input wire logic [15:0] crcIn,
  input wire logic [7:0] dataIn,
  input wire logic lsbFirst,
  output logic [15:0] crcOut
);
  function automatic logic [7:0] bsc_reverse8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : bsc_reverse8

  always_comb begin
    logic [7:0] d;
    logic [15:0] c;
    logic fb;
    d = lsbFirst ? bsc_reverse8(dataIn) : dataIn;
    c = crcIn;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ `BSC_POLY;
      end
    end
    crcOut = c;
  end
endmodule : bsc_crc_step
`default_nettype wire

/* File: logic/bsc_crc16.sv */
// wishbone crc16 calculator with control and data registers
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`default_nettype none
`include "bsc_regs.svh"
module bsc_crc16 (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  bsc_pkg::bsc_bus_t busState;
  bsc_pkg::bsc_bus_t next_busState;
  logic [15:0] checksum;
  logic [15:0] next_checksum;
  logic seedSelect;
  logic next_seedSelect;
  logic orderSelect;
  logic next_orderSelect;
  logic [31:0] next_wbDat;
  logic [31:0] wbDat;
  logic [15:0] stepOut;
  logic request;
  logic doWrite;
  logic [7:0] controlRead;

  assign request = wb_cyc_i && wb_stb_i;
  // one access per handshake; ack drops the cycle after it rose
  assign doWrite = request && wb_we_i && wb_sel_i[0] && (busState == bsc_pkg::BSC_IDLE);
  assign controlRead = {5'h00, orderSelect, seedSelect, 1'b0};

  bsc_crc_step stepUnit (
    .crcIn(checksum),
    .dataIn(wb_dat_i[7:0]),
    .lsbFirst(orderSelect),
    .crcOut(stepOut)
  );

  always_comb begin
    next_busState = bsc_pkg::BSC_IDLE;
    case (busState)
      bsc_pkg::BSC_IDLE: begin
        if (request) begin
          next_busState = bsc_pkg::BSC_ACK;
        end
      end
      bsc_pkg::BSC_ACK: begin
        next_busState = bsc_pkg::BSC_IDLE;
      end
      default: begin
        next_busState = bsc_pkg::BSC_IDLE;
      end
    endcase
  end

  always_comb begin
    next_checksum = checksum;
    next_seedSelect = seedSelect;
    next_orderSelect = orderSelect;
    if (doWrite && wb_adr_i == `BSC_OFS_CONTROL) begin
      next_seedSelect = wb_dat_i[`BSC_BIT_SEED_SELECT];
      next_orderSelect = wb_dat_i[`BSC_BIT_ORDER_SELECT];
      if (wb_dat_i[`BSC_BIT_RESET_TRIGGER]) begin
        // seed from the newly written select
        next_checksum = wb_dat_i[`BSC_BIT_SEED_SELECT] ? `BSC_SEED_ONES : `BSC_SEED_ZERO;
      end
    end
    // one byte per write, no command
    if (doWrite && wb_adr_i == `BSC_OFS_DATA_LOW) begin
      next_checksum = stepOut;
    end
  end

  always_comb begin
    next_wbDat = 32'h0000_0000;
    if (request && !wb_we_i && busState == bsc_pkg::BSC_IDLE) begin
      case (wb_adr_i)
        `BSC_OFS_CONTROL: next_wbDat = {24'h000000, controlRead};
        `BSC_OFS_DATA_LOW: next_wbDat = {24'h000000, checksum[7:0]};
        `BSC_OFS_DATA_HIGH: next_wbDat = {24'h000000, checksum[15:8]};
        default: next_wbDat = 32'h0000_0000;
      endcase
    end
  end

  // registered in the edge of the write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busState <= bsc_pkg::BSC_IDLE;
      checksum <= `BSC_SEED_ZERO;
      seedSelect <= 1'b0;
      orderSelect <= 1'b0;
      wbDat <= 32'h0000_0000;
    end else begin
      busState <= next_busState;
      checksum <= next_checksum;
      seedSelect <= next_seedSelect;
      orderSelect <= next_orderSelect;
      wbDat <= next_wbDat;
    end
  end

  assign wb_ack_o = (busState == bsc_pkg::BSC_ACK);
  assign wb_dat_o = wbDat;

  // checks look one edge after the request was taken, so read checks
  // compare wb_dat_o against $past of the state that fed the read mux

  a_data_fold: assert property (@(posedge clk) disable iff (!reset_n)
    doWrite && wb_adr_i == `BSC_OFS_DATA_LOW |=> checksum == $past(stepOut))
    else $error("checksum did not fold written byte");

  a_fold_once: assert property (@(posedge clk) disable iff (!reset_n)
    doWrite && wb_adr_i == `BSC_OFS_DATA_LOW |=> !doWrite)
    else $error("byte folded twice");

  // a runaway engine that kept folding would move the checksum here
  // no write, no change
  a_quiet_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !doWrite |=> $stable(checksum))
    else $error("checksum moved without a write");

  // high and unmapped writes are acked but must leave no trace
  // other writes keep checksum
  a_other_hold: assert property (@(posedge clk) disable iff (!reset_n)
    doWrite && wb_adr_i != `BSC_OFS_CONTROL && wb_adr_i != `BSC_OFS_DATA_LOW
    |=> $stable(checksum))
    else $error("unrelated write changed checksum");

  // only byte lane 0 carries a register, so sel[0] gates the write
  // masked lane skips fold
  a_sel_skip: assert property (@(posedge clk) disable iff (!reset_n)
    request && wb_we_i && !wb_sel_i[0] |=> $stable(checksum))
    else $error("masked write changed checksum");

  a_read_calm: assert property (@(posedge clk) disable iff (!reset_n)
    request && !wb_we_i |=> $stable(checksum))
    else $error("read changed checksum");

  // seed follows the select written in the same access
  // seed from select
  a_seed_load: assert property (@(posedge clk) disable iff (!reset_n)
    doWrite && wb_adr_i == `BSC_OFS_CONTROL && wb_dat_i[0]
    |=> checksum == (seedSelect ? 16'hffff : 16'h0000))
    else $error("seed not loaded");

  a_seed_ones: assert property (@(posedge clk) disable iff (!reset_n)
    doWrite && wb_adr_i == `BSC_OFS_CONTROL && wb_dat_i[1:0] == 2'b11
    |=> checksum == `BSC_SEED_ONES)
    else $error("all-ones seed not loaded");

  a_seed_zero: assert property (@(posedge clk) disable iff (!reset_n)
    doWrite && wb_adr_i == `BSC_OFS_CONTROL && wb_dat_i[1:0] == 2'b01
    |=> checksum == `BSC_SEED_ZERO)
    else $error("zero seed not loaded");

  a_seed_stored: assert property (@(posedge clk) disable iff (!reset_n)
    doWrite && wb_adr_i == `BSC_OFS_CONTROL
    |=> seedSelect == $past(wb_dat_i[`BSC_BIT_SEED_SELECT]))
    else $error("seed select not stored");

  a_select_hold: assert property (@(posedge clk) disable iff (!reset_n)
    doWrite && wb_adr_i == `BSC_OFS_CONTROL && !wb_dat_i[0]
    |=> $stable(checksum))
    else $error("select changed checksum");

  // a read or a data write must not disturb the mode bits
  // selects change on write only
  a_select_stable: assert property (@(posedge clk) disable iff (!reset_n)
    !(doWrite && wb_adr_i == `BSC_OFS_CONTROL)
    |=> $stable(seedSelect) && $stable(orderSelect))
    else $error("select moved without a control write");

  a_trigger_zero: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `BSC_OFS_CONTROL
    |-> wb_dat_o[0] == 1'b0)
    else $error("trigger bit read as one");

  a_order_used: assert property (@(posedge clk) disable iff (!reset_n)
    doWrite && wb_adr_i == `BSC_OFS_CONTROL |=> orderSelect == $past(wb_dat_i[2]))
    else $error("order select not stored");

  a_ctrl_fields: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `BSC_OFS_CONTROL
    |-> wb_dat_o[2:1] == $past({orderSelect, seedSelect}))
    else $error("control selects read wrong");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o && $past(wb_adr_i) == `BSC_OFS_CONTROL |-> wb_dat_o[7:3] == 5'h00)
    else $error("reserved control bits nonzero");

  a_high_read: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `BSC_OFS_DATA_HIGH
    |-> wb_dat_o[7:0] == $past(checksum[15:8]))
    else $error("high byte read wrong");

  a_high_nowrite: assert property (@(posedge clk) disable iff (!reset_n)
    doWrite && wb_adr_i == `BSC_OFS_DATA_HIGH |=> $stable(checksum))
    else $error("high write changed checksum");

  a_low_read: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `BSC_OFS_DATA_LOW
    |-> wb_dat_o[7:0] == $past(checksum[7:0]))
    else $error("low byte read wrong");

  a_upper_zero: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read lanes nonzero");

  a_write_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0000_0000)
    else $error("write answer carried data");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) != `BSC_OFS_CONTROL
    && $past(wb_adr_i) != `BSC_OFS_DATA_LOW && $past(wb_adr_i) != `BSC_OFS_DATA_HIGH
    |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read nonzero");

  // keeps stale read data off the bus between accesses
  // read data only with ack
  a_dat_settle: assert property (@(posedge clk) disable iff (!reset_n)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside an answer");

  a_ack_single: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // fixed one-cycle answer; the slave never stretches a transfer
  // ack next cycle
  a_ack_prompt: assert property (@(posedge clk) disable iff (!reset_n)
    request && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");

  a_fold_ack: assert property (@(posedge clk) disable iff (!reset_n)
    doWrite |=> wb_ack_o)
    else $error("write not answered");

  a_ack_cause: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o |-> $past(request))
    else $error("ack without request");

  a_idle_ack: assert property (@(posedge clk) disable iff (!reset_n)
    !request |=> !wb_ack_o)
    else $error("ack while bus idle");

  // main scenarios for coverage
  // the masked-lane cover shows that sel[0] low is really reached
  c_data_write: cover property (@(posedge clk) doWrite && wb_adr_i == `BSC_OFS_DATA_LOW);
  c_seed_ones: cover property (@(posedge clk)
    doWrite && wb_adr_i == `BSC_OFS_CONTROL && wb_dat_i[1:0] == 2'b11);
  c_lsb_write: cover property (@(posedge clk)
    doWrite && wb_adr_i == `BSC_OFS_DATA_LOW && orderSelect);
  c_high_read: cover property (@(posedge clk)
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `BSC_OFS_DATA_HIGH);
  c_sel_skip: cover property (@(posedge clk)
    request && wb_we_i && !wb_sel_i[0] && busState == bsc_pkg::BSC_IDLE);
endmodule : bsc_crc16
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the wishbone crc16 calculator
`default_nettype none
`include "bsc_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] CA = `BSC_OFS_CONTROL;
  localparam logic [3:0] LA = `BSC_OFS_DATA_LOW;
  localparam logic [3:0] HA = `BSC_OFS_DATA_HIGH;
  logic clk, reset_n, cyc, stb, we, ack, seedSel, lsb;
  logic [3:0] adr, sel;
  logic [31:0] datI, datO, rd;
  logic [15:0] crc;
  logic [7:0] d;
  int bad_count, compares;
  bsc_crc16 dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // msb-first shift; lsb-first just feeds the bits reversed
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b,
    input logic l);
    logic f;
    for (int i = 7; i >= 0; i--) begin
      f = c[15] ^ (l ? b[7 - i] : b[i]);
      c = f ? ({c[14:0], 1'b0} ^ `BSC_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction : crc_step
  // request held until ack is seen high at a rising edge; data taken there
  task automatic wb_cycle(input logic w, input logic [3:0] a, input logic [7:0] v);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= {24'h000000, v};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t no ack", $time);
    end
    rd = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb_cycle
  task automatic chk(input logic [31:0] got, input logic [7:0] e);
    compares++;
    if (got !== {24'h000000, e}) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, e);
    end
  endtask : chk
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    wb_cycle(1'b0, a, 8'h00);
    chk(rd, e);
  endtask : rdchk
  task automatic wrap_up;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #500000;
    bad_count++;
    wrap_up;
  end
  initial begin
    {cyc, stb, we, adr, datI, bad_count, compares} = '0;
    sel = 4'hf;
    reset_n = 1'b0;
    void'($urandom(28));
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdchk(CA, 8'h00);
    rdchk(HA, 8'h00);
    // reserved bits dropped, trigger seeds all ones
    wb_cycle(1'b1, CA, 8'hff);
    {seedSel, lsb, crc} = {2'b11, `BSC_SEED_ONES};
    rdchk(CA, 8'h06);
    rdchk(LA, crc[7:0]);
    rdchk(HA, crc[15:8]);
    for (int i = 0; i < 48; i++) begin
      d = (i == 1) ? 8'h00 : (i == 2) ? 8'hff : 8'($urandom);
      if (i % 6 == 0) begin
        lsb = 1'($urandom);
        wb_cycle(1'b1, CA, {5'h00, lsb, seedSel, 1'b0});
        rdchk(CA, {5'h00, lsb, seedSel, 1'b0});
      end
      wb_cycle(1'b1, LA, d);
      crc = crc_step(crc, d, lsb);
      rdchk(LA, crc[7:0]);
      rdchk(HA, crc[15:8]);
    end
    wb_cycle(1'b1, HA, ~crc[15:8]);
    rdchk(HA, crc[15:8]);
    // unmapped accesses are acked, read zero and leave no trace
    wb_cycle(1'b1, 4'hc, 8'h5a);
    rdchk(4'hc, 8'h00);
    rdchk(LA, crc[7:0]);
    // low byte lane off: the write is acked but must not fold
    sel <= 4'he;
    wb_cycle(1'b1, LA, 8'h77);
    sel <= 4'hf;
    rdchk(LA, crc[7:0]);
    // mid-run reset clears checksum and both selects
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    {seedSel, lsb, crc} = {2'b00, `BSC_SEED_ZERO};
    rdchk(CA, 8'h00);
    rdchk(LA, crc[7:0]);
    rdchk(HA, crc[15:8]);
    for (int s = 0; s < 2; s++) begin
      seedSel = 1'(s);
      wb_cycle(1'b1, CA, {5'h00, lsb, seedSel, 1'b0});
      rdchk(HA, crc[15:8]);
      wb_cycle(1'b1, CA, {5'h00, lsb, seedSel, 1'b1});
      crc = seedSel ? `BSC_SEED_ONES : `BSC_SEED_ZERO;
      rdchk(LA, crc[7:0]);
      wb_cycle(1'b1, LA, 8'h31);
      crc = crc_step(crc, 8'h31, lsb);
      rdchk(HA, crc[15:8]);
    end
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
